// File: core/mcu_cfg_pkg.sv
// package of register offsets, field positions, reset values and encodings
// for the memory controller configuration register bank.
// assumes a 32-bit apb master with byte addresses equal to four times the index.
package mcu_cfg_pkg;

    // ==========================================================
    // register indices (byte address = index * 4)
    localparam logic [7:0] idx_chip_identifier   = 8'h20;
    localparam logic [7:0] idx_capability_report = 8'h21;
    localparam logic [7:0] idx_cache_control     = 8'h22;
    localparam logic [7:0] idx_burst_option      = 8'h23;
    localparam logic [7:0] idx_dram_options_one  = 8'h24;

    // ==========================================================
    // identity and reset values
    // revision and controller codes: arbitrary neutral values
    localparam logic [3:0] revision_code    = 4'h5;
    localparam logic [3:0] controller_code  = 4'h9;
    localparam logic       double_index_sup = 1'b0;
    localparam logic [7:0] capability_reset = 8'h01;
    localparam logic [7:0] cache_reset      = 8'h00;
    localparam logic [7:0] dram_one_reset   = 8'h00;
    localparam logic       burst_reset      = 1'b0;

    // ==========================================================
    // field positions
    localparam int cap_pipeline_bit   = 0;
    localparam int cap_double_idx_bit = 2;
    localparam int cc_enable_bit      = 0;
    localparam int cc_size_lo         = 2;
    localparam int cc_assoc_bit       = 4;
    localparam int cc_flush_bit       = 5;
    localparam int dr_banks_lo        = 0;
    localparam int dr_ilv_lo          = 2;
    localparam int dr_paging_bit      = 5;
    localparam int dr_refresh_bit     = 6;
    localparam int dr_staggered_refresh_en_bit     = 7;
    localparam int burst_bit          = 0;

    // ==========================================================
    // encodings
    typedef enum logic [1:0] {
        size_32k  = 2'b00,
        size_64k  = 2'b01,
        size_128k = 2'b10,
        size_rsvd = 2'b11
    } cache_size_type;

    typedef enum logic [2:0] {
        ilv_none     = 3'b000,
        ilv_two_low  = 3'b001,
        ilv_two_high = 3'b010,
        ilv_two_both = 3'b011,
        ilv_four     = 3'b100
    } interleave_type;

endpackage : mcu_cfg_pkg

// File: core/cfg_write_if.sv
// interface carrying a decoded register write between the apb front end
// and the register store. assumes one clock domain.
`timescale 1ns/1ns
interface cfg_write_if;
    logic       wr_en;
    logic [7:0] wr_index;
    logic [7:0] wr_data;
    logic [7:0] rd_index;
    logic [7:0] rd_data;
    logic       rd_hit;

    modport front (output wr_en, output wr_index, output wr_data,
                   output rd_index, input rd_data, input rd_hit);
    modport store (input wr_en, input wr_index, input wr_data,
                   input rd_index, output rd_data, output rd_hit);
endinterface : cfg_write_if

// File: core/cfg_store.sv
// register store of the configuration bank: holds writable registers and
// answers reads by index. assumes writes arrive as single-cycle strobes.
`timescale 1ns/1ns
module cfg_store (
    input  wire logic        pclk,
    input  wire logic        presetn,
    cfg_write_if.store       port,
    output      logic [7:0]  cache_reg,
    output      logic [7:0]  dram_reg,
    output      logic        burst_reg
);
    import mcu_cfg_pkg::*;

    logic [7:0] next_cache_reg;
    logic [7:0] next_dram_reg;
    logic       next_burst_reg;

    // ==========================================================
    // write decode
    always_comb begin
        next_cache_reg = cache_reg;
        next_dram_reg  = dram_reg;
        next_burst_reg = burst_reg;
        if (port.wr_en) begin
            case (port.wr_index)
                idx_cache_control:    next_cache_reg = port.wr_data;  // R4
                idx_dram_options_one: next_dram_reg  = port.wr_data;  // R10
                idx_burst_option:     next_burst_reg = port.wr_data[burst_bit]; // R15
                default: ;  // identifier and capability writes ignored R1 R2
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cache_reg <= cache_reset;
            dram_reg  <= dram_one_reset;   // R10
            burst_reg <= burst_reset;      // R15
        end else begin
            cache_reg <= next_cache_reg;   // R14
            dram_reg  <= next_dram_reg;
            burst_reg <= next_burst_reg;
        end
    end

    // ==========================================================
    // read mux
    always_comb begin
        port.rd_data = 8'h00;
        port.rd_hit  = 1'b1;
        case (port.rd_index)
            idx_chip_identifier:   port.rd_data = {controller_code, revision_code}; // R1
            idx_capability_report: begin
                port.rd_data = capability_reset;                       // R2
                port.rd_data[cap_double_idx_bit] = double_index_sup;   // R3
            end
            idx_cache_control:     port.rd_data = cache_reg;
            idx_burst_option:      port.rd_data = {7'h00, burst_reg};
            idx_dram_options_one:  port.rd_data = dram_reg;
            default:               port.rd_hit  = 1'b0;
        endcase
    end
endmodule : cfg_store

// File: core/memory_ctrl_config_regs.sv
// top of the memory controller configuration register bank: apb slave,
// register store and decoded configuration outputs for cache and dram logic.
// assumes a single pclk domain and an apb master that holds each request.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ns

// Notes on behaviour
// R1: identifier returns revision low, controller code high
// R2: capability resets 01h, pipeline bit set, read-only
// R3: capability bit 2 reports second-level indexing support
// R4: cache bit 0 enables cache; reserved preserved
// R5: cache size 32k, 64k, 128k; 11 reserved
// R6: bit 4 direct-mapped, bit 5 flush enable
// R7: zero-wait option affects only read-miss burst
// R8: disabled option adds one wait per fill beat
// R9: software enables zero-wait only with latching rams
// R10: dram options one resets 00h, read-write
// R11: bank count field bits 1:0
// R12: interleave field bits 4:2; 101-111 forbidden
// R13: paging, refresh type, staggered refresh bits 5-7
// R14: indexed registers drive stable outputs on write
// R15: zero-wait option in writable bit, resets off
module memory_ctrl_config_regs (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [11:0]                 paddr,
    input  wire logic [31:0]                 pwdata,
    input  wire logic [3:0]                  pstrb,
    output      logic [31:0]                 prdata,
    output      logic                        pready,
    output      logic                        pslverr,
    output      logic                        cache_enable,
    output      mcu_cfg_pkg::cache_size_type cache_size,
    output      logic                        cache_direct_mapped,
    output      logic                        cache_flush_enable,
    output      logic [1:0]                  dram_bank_count,
    output      mcu_cfg_pkg::interleave_type dram_interleave,
    output      logic                        dram_paging_en,
    output      logic                        dram_cbr_refresh,
    output      logic                        staggered_refresh_en,
    output      logic                        fill_wait_state
);
    import mcu_cfg_pkg::*;

    cfg_write_if bus ();

    logic [7:0] cache_reg;
    logic [7:0] dram_reg;
    logic       burst_reg;

    // ==========================================================
    // apb front end: one wait state per access, answers in the access phase
    logic        access;
    logic        aligned;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;

    assign access       = psel && penable && !pready;
    assign aligned      = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
    assign bus.rd_index = paddr[9:2];                                   // R14
    assign bus.wr_index = paddr[9:2];
    assign bus.wr_data  = pwdata[7:0];
    // low byte lane carries the register; writes without it change nothing.
    // the write lands at the edge that completes the transfer, never earlier,
    // and only when the answer carries no error
    assign bus.wr_en    = psel && penable && pready && !pslverr && pwrite && pstrb[0]; // R14

    always_comb begin
        next_prdata  = 32'h0000_0000;
        next_pready  = 1'b0;
        next_pslverr = 1'b0;
        if (access) begin
            next_pready  = 1'b1;
            next_pslverr = !(aligned && bus.rd_hit);
            if (!pwrite && aligned && bus.rd_hit) begin
                next_prdata = {24'h00_0000, bus.rd_data};
            end
        end
    end

    // pready goes high one cycle into the access phase, so every transfer has
    // exactly one wait state; this keeps prdata straight from a flip-flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    cfg_store u_store (
        .pclk      (pclk),
        .presetn   (presetn),
        .port      (bus),
        .cache_reg (cache_reg),
        .dram_reg  (dram_reg),
        .burst_reg (burst_reg)
    );

    // ==========================================================
    // decoded configuration outputs, registered once more so they stay glitch free
    logic           next_cache_enable;
    cache_size_type next_cache_size;
    logic           next_direct;
    logic           next_flush;
    logic [1:0]     next_banks;
    interleave_type next_ilv;
    logic           next_paging;
    logic           next_cbr;
    logic           next_staggered_refresh_en;
    logic           next_fill_wait;

    always_comb begin
        next_cache_enable = cache_reg[cc_enable_bit];                     // R4
        next_cache_size   = cache_size_type'(cache_reg[cc_size_lo +: 2]); // R5
        next_direct       = cache_reg[cc_assoc_bit];                      // R6
        next_flush        = cache_reg[cc_flush_bit];                      // R6
        next_banks        = dram_reg[dr_banks_lo +: 2];                   // R11
        // forbidden interleave codes fall back to none rather than guessing
        case (dram_reg[dr_ilv_lo +: 3])
            3'b000:  next_ilv = ilv_none;                                 // R12
            3'b001:  next_ilv = ilv_two_low;
            3'b010:  next_ilv = ilv_two_high;
            3'b011:  next_ilv = ilv_two_both;
            3'b100:  next_ilv = ilv_four;
            default: next_ilv = ilv_none;
        endcase
        next_paging    = dram_reg[dr_paging_bit];                         // R13
        next_cbr       = dram_reg[dr_refresh_bit];                        // R13
        next_staggered_refresh_en   = dram_reg[dr_staggered_refresh_en_bit];                        // R13
        // wait state on every line-fill beat unless zero-wait chosen; the
        // sequencer applies this only to read-miss fills
        next_fill_wait = !burst_reg;                                      // R7 R8
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cache_enable         <= 1'b0;
            cache_size           <= size_32k;
            cache_direct_mapped  <= 1'b0;
            cache_flush_enable   <= 1'b0;
            dram_bank_count      <= 2'b00;
            dram_interleave      <= ilv_none;
            dram_paging_en       <= 1'b0;
            dram_cbr_refresh     <= 1'b0;
            staggered_refresh_en <= 1'b0;
            fill_wait_state      <= 1'b1;
        end else begin
            cache_enable         <= next_cache_enable;
            cache_size           <= next_cache_size;
            cache_direct_mapped  <= next_direct;
            cache_flush_enable   <= next_flush;
            dram_bank_count      <= next_banks;
            dram_interleave      <= next_ilv;
            dram_paging_en       <= next_paging;
            dram_cbr_refresh     <= next_cbr;
            staggered_refresh_en <= next_staggered_refresh_en;
            fill_wait_state      <= next_fill_wait;
        end
    end

endmodule : memory_ctrl_config_regs

// File: tb/cfg_regs_chk.sv
// checker of the apb handshake and the fixed register reads
// assumes it is bound into memory_ctrl_config_regs on one pclk domain
`timescale 1ns/1ns
module cfg_regs_chk
    import mcu_cfg_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        cache_enable,
    input wire logic        fill_wait_state
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================
    // handshake
    property p_lat; psel && penable && !pready |=> pready; endproperty
    a_lat: assert property (p_lat) else $error("ready late");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready too long");
    property p_ctx; pready |-> psel && penable; endproperty
    a_ctx: assert property (p_ctx) else $error("ready outside access");
    property p_idle; !pready |-> prdata == 32'h0000_0000; endproperty
    a_idle: assert property (p_idle) else $error("read data not idle");
    property p_err; pready && paddr[1:0] != 2'b00 |-> pslverr; endproperty
    a_err: assert property (p_err) else $error("misaligned not refused");
    // ==========================================
    // fixed reads and output stability
    property p_up; pready && !pwrite |-> prdata[31:8] == 24'h00_0000; endproperty
    a_up: assert property (p_up) else $error("upper bits set");
    property p_id; pready && !pwrite && paddr == 12'h080
        |-> prdata[7:0] == {controller_code, revision_code}; endproperty
    a_id: assert property (p_id) else $error("identifier wrong");
    property p_cap; pready && !pwrite && paddr == 12'h084
        |-> prdata[7:0] == capability_reset; endproperty
    a_cap: assert property (p_cap) else $error("capability wrong");
    property p_dbl; pready && !pwrite && paddr == 12'h084
        |-> prdata[cap_double_idx_bit] == double_index_sup; endproperty
    a_dbl: assert property (p_dbl) else $error("index support wrong");
    // a write may move the outputs up to two edges after its access ends
    property p_hold; !(psel && pwrite) [*3] |=> $stable({cache_enable, fill_wait_state});
    endproperty
    a_hold: assert property (p_hold) else $error("output moved");
endmodule : cfg_regs_chk
bind memory_ctrl_config_regs cfg_regs_chk u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cache_enable(cache_enable), .fill_wait_state(fill_wait_state));

// File: tb/tb.sv
// self-checking bench of the configuration register bank over apb
// assumes the design package is compiled first and the checker is bound
`timescale 1ns/1ns
module tb;
    import mcu_cfg_pkg::*;
    logic           pclk = 1'b0;
    logic           presetn = 1'b0;
    logic           psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0]    paddr = 12'h000;
    logic [31:0]    pwdata = 32'h0000_0000;
    logic [3:0]     pstrb = 4'hF;
    logic [31:0]    prdata, rd;
    logic           pready, pslverr, err;
    logic           cache_enable, cache_direct_mapped, cache_flush_enable;
    cache_size_type cache_size;
    interleave_type dram_interleave;
    logic [1:0]     dram_bank_count;
    logic           dram_paging_en, dram_cbr_refresh, staggered_refresh_en, fill_wait_state;
    logic [7:0]     lf = 8'h52;
    logic [7:0]     cd, dd;
    int             num_errors = 0, comparisons = 0;
    always #25 pclk = ~pclk;
    memory_ctrl_config_regs DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cache_enable(cache_enable), .cache_size(cache_size),
        .cache_direct_mapped(cache_direct_mapped), .cache_flush_enable(cache_flush_enable),
        .dram_bank_count(dram_bank_count), .dram_interleave(dram_interleave),
        .dram_paging_en(dram_paging_en), .dram_cbr_refresh(dram_cbr_refresh),
        .staggered_refresh_en(staggered_refresh_en), .fill_wait_state(fill_wait_state));
    // ==========================================
    // helpers
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr
    function automatic logic [11:0] ad(input logic [7:0] i);
        return {2'b00, i, 2'b00};
    endfunction : ad
    // reserved interleave codes fall back to none
    function automatic logic [2:0] exp_ilv(input logic [7:0] d);
        return (d[4:2] > 3'd4) ? 3'd0 : d[4:2];
    endfunction : exp_ilv
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test;
        if (num_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            num_errors++;
            end_of_test();
        end
    endtask : apb
    // ==========================================
    // scenarios
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        check(fill_wait_state, 1);
        apb(0, ad(idx_chip_identifier), 0); check(rd, {controller_code, revision_code});
        apb(0, ad(idx_capability_report), 0); check(rd, capability_reset);
        check(rd[cap_double_idx_bit], double_index_sup);
        apb(0, ad(idx_dram_options_one), 0); check(rd, dram_one_reset);
        apb(0, ad(idx_burst_option), 0); check(rd, burst_reset);
        apb(1, ad(idx_chip_identifier), 8'hFF);
        apb(1, ad(idx_capability_report), 8'hFE);
        apb(0, ad(idx_chip_identifier), 0); check(rd, {controller_code, revision_code});
        apb(0, ad(idx_capability_report), 0); check(rd, capability_reset);
        // software keeps the reserved cache bits as they stand
        cd = cache_reset;
        for (int i = 0; i < 15; i++) begin
            lf = lfsr(lf);
            cd = {cd[7:6], lf[5:2], cd[1], lf[0]};
            cd[3:2] = 2'(i % 3);
            dd = lfsr(lf);
            dd[4:2] = 3'(i % 5);
            dd[1:0] = 2'(i % 4);
            apb(1, ad(idx_cache_control), cd);
            apb(1, ad(idx_dram_options_one), dd);
            apb(0, ad(idx_cache_control), 0); check(rd, cd);
            apb(0, ad(idx_dram_options_one), 0); check(rd, dd);
            check({cache_flush_enable, cache_direct_mapped, cache_size, cache_enable},
                  {cd[5:4], cd[3:2], cd[0]});
            check({staggered_refresh_en, dram_cbr_refresh, dram_paging_en, dram_interleave,
                   dram_bank_count}, {dd[7:5], exp_ilv(dd), dd[1:0]});
        end
        for (int b = 1; b >= 0; b--) begin
            // latching data rams are taken as fitted, so zero-wait may be chosen
            apb(1, ad(idx_burst_option), 8'(b));
            apb(0, ad(idx_burst_option), 0); check(rd, b);
            check(fill_wait_state, !b);
        end
        apb(0, 12'h3FC, 0); check(err, 1);
        apb(1, ad(idx_cache_control) | 12'h001, cd ^ 8'h31); check(err, 1);
        apb(0, ad(idx_cache_control), 0); check(rd, cd);
        check(err, 0);
        // a write without the low byte lane is answered but stores nothing
        pstrb <= 4'hE;
        apb(1, ad(idx_cache_control), cd ^ 8'h31); check(err, 0);
        pstrb <= 4'hF;
        apb(0, ad(idx_cache_control), 0); check(rd, cd);
        // reset in mid-run must bring every register back to its reset value
        apb(1, ad(idx_burst_option), 8'h01);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        check(fill_wait_state, 1);
        check({dram_bank_count, dram_interleave, staggered_refresh_en}, 0);
        apb(0, ad(idx_dram_options_one), 0); check(rd, dram_one_reset);
        apb(0, ad(idx_burst_option), 0); check(rd, burst_reset);
        apb(0, ad(idx_cache_control), 0); check(rd, cache_reset);
        end_of_test();
    end
    // the whole sequence needs well under a thousand cycles
    initial begin
        #100000;
        num_errors++;
        end_of_test();
    end
endmodule : tb
